// ### hdl/lso_map.svh
// Offsets, field positions, reset values and space tag codes of the ordering unit.
// Assumes inclusion by bare name before the modules that use it.
`ifndef LSO_MAP_SVH
`define LSO_MAP_SVH
`define LSO_OFF_CTRL 8'h00
`define LSO_OFF_TAG 8'h04
`define LSO_OFF_STATUS 8'h08
`define LSO_OFF_MASK 8'h0C
`define LSO_OFF_QSTATE 8'h10
`define LSO_CTRL_MERGE 0
`define LSO_RST_CTRL 8'h01
`define LSO_RST_TAG 8'h80
`define LSO_RST_MASK 8'h00
`define LSO_EV_TRAP 0
`define LSO_EV_PFDROP 1
`define LSO_EV_SEHOLD 2
`define LSO_EV_WIDTH 3
`define LSO_TAG_LE_BIT 3
`define LSO_TAG_NF_MASK 8'hF6
`define LSO_TAG_NF_BASE 8'h82
`define LSO_TAG_REAL 8'h14
`define LSO_SQ_DEPTH 4
`define LSO_SQ_FULL 3'h4
`define LSO_REGION_LSB 4
`define LSO_LANE_BIT 3
`endif

// ### hdl/lso_pkg.sv
// Types shared by the ordering unit and its store queue.
// Assumes nothing beyond a SystemVerilog compiler.
package lso_pkg;
	typedef enum logic [1:0] {
		KIND_LOAD = 2'h0,
		KIND_STORE = 2'h1,
		KIND_PREFETCH = 2'h2
	} kind_type;
	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_WAIT = 5'h02,
		ST_RDREQ = 5'h04,
		ST_RDRSP = 5'h08,
		ST_WRREQ = 5'h10
	} state_type;
	typedef struct packed {
		logic [59:0] region;
		logic [7:0] tag;
		logic [127:0] data;
		logic [15:0] mask;
		logic sideEffect;
		logic cacheable;
		logic realAddr;
	} sq_entry_type;
endpackage : lso_pkg

// ### hdl/store_queue.sv
// Store queue: four flip-flop entries of one 16-byte region each, in order.
// Assumes the owner never pushes when full nor pops when empty.
`include "lso_map.svh"
module store_queue (
	input wire logic clk,
	input wire logic rstn,
	input wire logic push,
	input lso_pkg::sq_entry_type pushEntry,
	input wire logic mergeEnable,
	input wire logic pop,
	input wire logic [59:0] probeRegion,
	input wire logic [7:0] probeTag,
	output lso_pkg::sq_entry_type head,
	output logic [2:0] count,
	output logic empty,
	output logic full,
	output logic merge,
	output logic hit
);
	lso_pkg::sq_entry_type slot [`LSO_SQ_DEPTH];
	lso_pkg::sq_entry_type young;
	lso_pkg::sq_entry_type merged;
	logic [1:0] headIdx;
	logic [1:0] tailIdx;
	logic [1:0] youngIdx;
	logic [`LSO_SQ_DEPTH-1:0] match;
	logic [127:0] byteKeep;
	logic sameTarget;
	genvar i;

	assign youngIdx = tailIdx - 2'h1;
	assign young = slot[youngIdx];
	assign head = slot[headIdx];
	assign empty = count == 3'h0;
	assign full = count == `LSO_SQ_FULL;
	assign sameTarget = young.region == pushEntry.region && young.tag == pushEntry.tag
		&& young.cacheable == pushEntry.cacheable && young.realAddr == pushEntry.realAddr;
	// Never merge into an entry leaving this cycle
	assign merge = push && mergeEnable && !empty && !(pop && count == 3'h1)
		&& !pushEntry.sideEffect && !young.sideEffect && sameTarget;

	generate
		for (i = 0; i < `LSO_SQ_DEPTH; i++) begin : g_probe
			logic [1:0] age;
			assign age = 2'(i) - headIdx;
			assign match[i] = ({1'b0, age} < count) && slot[i].region == probeRegion
				&& slot[i].tag == probeTag;
		end
		for (i = 0; i < 16; i++) begin : g_keep
			assign byteKeep[i*8 +: 8] = {8{~pushEntry.mask[i]}};
		end
	endgenerate
	assign hit = |match;

	always_comb begin
		merged = young;
		merged.data = (young.data & byteKeep) | pushEntry.data;
		merged.mask = young.mask | pushEntry.mask;
	end

	always_ff @(posedge clk) begin
		if (merge) begin
			slot[youngIdx] <= merged;
		end else if (push) begin
			slot[tailIdx] <= pushEntry;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			headIdx <= 2'h0;
			tailIdx <= 2'h0;
			count <= 3'h0;
		end else begin
			headIdx <= headIdx + 2'(pop);
			tailIdx <= tailIdx + 2'(push && !merge);
			count <= count + 3'(push && !merge) - 3'(pop);
		end
	end
endmodule : store_queue

// ### hdl/lso_unit.sv
// Load/store ordering unit between the pipeline and the cache/system bus port.
// Assumes one request at a time from the pipeline, all ports synchronous to clk.
//
// Contract
// - Loads and stores appear to the program to act in program order.
// - Every access carries an 8-bit space tag and a 64-bit address.
// - The tag comes from the space-tag register or from the instruction.
// - The tag picks the space and sets byte order and real addressing.
// - Total store order holds across cacheable and noncacheable accesses.
// - Cacheable accesses target memory; lines are power-of-two, at least 16 bytes.
// - Only cacheable accesses join coherency; noncacheable ones bypass it.
// - Noncacheable transfers may be as small as one byte.
// - Plain noncacheable accesses are TSO; a load sees the earlier store.
// - Side-effect noncacheable accesses are strongly ordered, in program order.
// - Side-effect loads wait for earlier instructions and an empty store queue.
// - Stores to side-effect pages are never merged.
// - Nonfaulting loads to side-effect pages trap.
// - Noncacheable prefetches complete as no-ops without access.
// - I/O accesses follow the same ordering as memory accesses.
// - Speculative instruction fetch from translated addresses is allowed.
//
// Design decisions made here: the plain strobed port and the placing of the registers.
`include "lso_map.svh"
module lso_unit (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [7:0] regAddr,
	input wire logic [31:0] regWdata,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [31:0] regRdata,
	input wire logic reqValid,
	output logic reqReady,
	input wire logic [1:0] reqKind,
	input wire logic reqUseInstTag,
	input wire logic [7:0] reqInstTag,
	input wire logic [63:0] reqAddr,
	input wire logic [63:0] reqData,
	input wire logic [7:0] reqBytes,
	input wire logic reqCacheable,
	input wire logic reqSideEffect,
	input wire logic reqRetired,
	output logic rspValid,
	output logic rspTrap,
	output logic [63:0] rspData,
	output logic busValid,
	input wire logic busReady,
	output logic busWrite,
	output logic busPrefetch,
	output logic [7:0] busTag,
	output logic [63:0] busAddr,
	output logic [127:0] busData,
	output logic [15:0] busMask,
	output logic busCacheable,
	output logic busSideEffect,
	output logic busReal,
	input wire logic busRspValid,
	input wire logic [127:0] busRspData,
	output logic irq
);
	lso_pkg::state_type state;
	lso_pkg::state_type next_state;
	lso_pkg::sq_entry_type pushEntry;
	lso_pkg::sq_entry_type qHead;
	logic [7:0] ctrl;
	logic [7:0] spaceTagReg;
	logic [7:0] maskReg;
	logic [`LSO_EV_WIDTH-1:0] status;
	logic [`LSO_EV_WIDTH-1:0] next_status;
	logic [`LSO_EV_WIDTH-1:0] events;
	logic [31:0] readMux;
	logic [2:0] qCount;
	logic [3:0] fillAfter;
	logic qEmpty;
	logic qFull;
	logic qMerge;
	logic qHit;
	logic qPop;

	// Request held while a load or prefetch waits for its turn
	logic [63:0] curAddr;
	logic [7:0] curTag;
	logic [7:0] curBytes;
	logic curCache;
	logic curSide;
	logic curReal;
	logic curLittle;
	logic curPf;
	logic holdEmpty;
	logic needRetire;
	logic waitPending;

	logic reqTake;
	logic [7:0] tag;
	logic isLittle;
	logic isReal;
	logic isNf;
	logic isLoad;
	logic isStore;
	logic isPf;
	logic trapNf;
	logic pfDrop;
	logic storeIn;
	logic loadIn;
	logic seLoad;
	logic waitIn;
	logic drainGo;
	logic waitGo;
	logic readDone;
	logic [63:0] storeSwap;
	logic [63:0] loadLane;
	logic [63:0] loadSwap;
	logic [7:0] loadMaskHalf;
	genvar b;

	assign reqTake = reqValid && reqReady;
	assign tag = reqUseInstTag ? reqInstTag : spaceTagReg;
	assign isLittle = tag[`LSO_TAG_LE_BIT];
	assign isReal = tag == `LSO_TAG_REAL;
	assign isNf = (tag & `LSO_TAG_NF_MASK) == `LSO_TAG_NF_BASE;
	assign isLoad = reqKind == lso_pkg::KIND_LOAD;
	assign isStore = reqKind == lso_pkg::KIND_STORE;
	assign isPf = reqKind == lso_pkg::KIND_PREFETCH;
	assign trapNf = reqTake && isLoad && isNf && reqSideEffect;
	assign pfDrop = reqTake && isPf && !reqCacheable;
	assign storeIn = reqTake && isStore;
	assign loadIn = reqTake && isLoad && !trapNf;
	assign seLoad = loadIn && reqSideEffect && !reqCacheable;
	assign waitIn = loadIn || (reqTake && isPf && reqCacheable);

	// Byte order per tag; both directions swap within one doubleword
	generate
		for (b = 0; b < 8; b++) begin : g_swap
			assign storeSwap[b*8 +: 8] = isLittle ? reqData[(7-b)*8 +: 8] : reqData[b*8 +: 8];
			assign loadSwap[b*8 +: 8] = curLittle ? loadLane[(7-b)*8 +: 8] : loadLane[b*8 +: 8];
		end
	endgenerate
	assign loadLane = curAddr[`LSO_LANE_BIT] ? busRspData[127:64] : busRspData[63:0];
	assign loadMaskHalf = curBytes;

	// Stores enter the queue as one 16-byte region with byte enables
	always_comb begin
		pushEntry.region = reqAddr[63:`LSO_REGION_LSB];
		pushEntry.tag = tag;
		pushEntry.data = reqAddr[`LSO_LANE_BIT] ? {storeSwap, 64'h0000_0000_0000_0000}
			: {64'h0000_0000_0000_0000, storeSwap};
		pushEntry.mask = reqAddr[`LSO_LANE_BIT] ? {reqBytes, 8'h00} : {8'h00, reqBytes};
		pushEntry.sideEffect = reqSideEffect;
		pushEntry.cacheable = reqCacheable;
		pushEntry.realAddr = isReal;
	end

	store_queue u_queue (
		.clk(clk),
		.rstn(rstn),
		.push(storeIn),
		.pushEntry(pushEntry),
		.mergeEnable(ctrl[`LSO_CTRL_MERGE]),
		.pop(qPop),
		.probeRegion(reqAddr[63:`LSO_REGION_LSB]),
		.probeTag(tag),
		.head(qHead),
		.count(qCount),
		.empty(qEmpty),
		.full(qFull),
		.merge(qMerge),
		.hit(qHit)
	);

	// Stores leave strictly in order, one at a time, so TSO holds for every kind
	assign drainGo = !qEmpty && ((state == lso_pkg::ST_IDLE && !(reqTake && !isStore))
		|| (state == lso_pkg::ST_WAIT && holdEmpty));
	// Prefetches and plain loads to other regions pass queued stores; same-region and noncacheable side-effect loads wait for a drain
	assign waitGo = state == lso_pkg::ST_WAIT && (!holdEmpty
		|| (qEmpty && (!needRetire || reqRetired)));
	assign qPop = drainGo;
	assign readDone = (state == lso_pkg::ST_RDREQ && busReady && curPf)
		|| (state == lso_pkg::ST_RDRSP && busRspValid);

	always_comb begin
		case (state)
			lso_pkg::ST_IDLE: begin
				if (drainGo) begin
					next_state = lso_pkg::ST_WRREQ;
				end else if (waitIn) begin
					next_state = lso_pkg::ST_WAIT;
				end else begin
					next_state = lso_pkg::ST_IDLE;
				end
			end
			lso_pkg::ST_WAIT: begin
				if (waitGo) begin
					next_state = lso_pkg::ST_RDREQ;
				end else if (drainGo) begin
					next_state = lso_pkg::ST_WRREQ;
				end else begin
					next_state = lso_pkg::ST_WAIT;
				end
			end
			lso_pkg::ST_RDREQ: begin
				if (!busReady) begin
					next_state = lso_pkg::ST_RDREQ;
				end else if (curPf) begin
					next_state = lso_pkg::ST_IDLE;
				end else begin
					next_state = lso_pkg::ST_RDRSP;
				end
			end
			lso_pkg::ST_RDRSP: begin
				next_state = busRspValid ? lso_pkg::ST_IDLE : lso_pkg::ST_RDRSP;
			end
			lso_pkg::ST_WRREQ: begin
				if (!busReady) begin
					next_state = lso_pkg::ST_WRREQ;
				// Stale held fields must not reopen the wait state; only a parked request does
				end else if (waitPending) begin
					next_state = lso_pkg::ST_WAIT;
				end else begin
					next_state = lso_pkg::ST_IDLE;
				end
			end
			default: begin
				next_state = lso_pkg::ST_IDLE;
			end
		endcase
	end

	// A load or prefetch is parked until its bus turn, across any store drain
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			waitPending <= 1'b0;
		end else if (waitIn || (state == lso_pkg::ST_WAIT && drainGo)) begin
			waitPending <= 1'b1;
		end else if (waitGo) begin
			waitPending <= 1'b0;
		end
	end

	assign fillAfter = {1'b0, qCount} + 4'(storeIn) - 4'(qPop);

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state <= lso_pkg::ST_IDLE;
			reqReady <= 1'b0;
		end else begin
			state <= next_state;
			reqReady <= next_state == lso_pkg::ST_IDLE && fillAfter < 4'(`LSO_SQ_DEPTH);
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			curAddr <= 64'h0000_0000_0000_0000;
			curTag <= 8'h00;
			curBytes <= 8'h00;
			curCache <= 1'b0;
			curSide <= 1'b0;
			curReal <= 1'b0;
			curLittle <= 1'b0;
			curPf <= 1'b0;
			holdEmpty <= 1'b0;
			needRetire <= 1'b0;
		end else if (waitIn) begin
			curAddr <= reqAddr;
			curTag <= tag;
			curBytes <= reqBytes;
			curCache <= reqCacheable;
			curSide <= reqSideEffect;
			curReal <= isReal;
			curLittle <= isLittle;
			curPf <= isPf;
			holdEmpty <= seLoad || (loadIn && qHit);
			needRetire <= seLoad;
		end
	end

	// Bus port: loads and prefetches come from the held request, stores from the queue head
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			busValid <= 1'b0;
			busWrite <= 1'b0;
			busPrefetch <= 1'b0;
			busTag <= 8'h00;
			busAddr <= 64'h0000_0000_0000_0000;
			busData <= '0;
			busMask <= 16'h0000;
			busCacheable <= 1'b0;
			busSideEffect <= 1'b0;
			busReal <= 1'b0;
		end else if (waitGo) begin
			busValid <= 1'b1;
			busWrite <= 1'b0;
			busPrefetch <= curPf;
			busTag <= curTag;
			busAddr <= curAddr;
			busMask <= curAddr[`LSO_LANE_BIT] ? {loadMaskHalf, 8'h00} : {8'h00, loadMaskHalf};
			busCacheable <= curCache;
			busSideEffect <= curSide;
			busReal <= curReal;
		end else if (drainGo) begin
			busValid <= 1'b1;
			busWrite <= 1'b1;
			busPrefetch <= 1'b0;
			busTag <= qHead.tag;
			busAddr <= {qHead.region, 4'h0};
			busData <= qHead.data;
			busMask <= qHead.mask;
			busCacheable <= qHead.cacheable;
			busSideEffect <= qHead.sideEffect;
			busReal <= qHead.realAddr;
		end else if (busReady) begin
			busValid <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rspValid <= 1'b0;
			rspTrap <= 1'b0;
			rspData <= 64'h0000_0000_0000_0000;
		end else begin
			rspValid <= trapNf || pfDrop || readDone;
			rspTrap <= trapNf;
			rspData <= (state == lso_pkg::ST_RDRSP && busRspValid) ? loadSwap : 64'h0000_0000_0000_0000;
		end
	end

	// Registers; status clears on read but a same-cycle event still lands
	assign events[`LSO_EV_TRAP] = trapNf;
	assign events[`LSO_EV_PFDROP] = pfDrop;
	assign events[`LSO_EV_SEHOLD] = seLoad;
	assign next_status = (regRead && regAddr == `LSO_OFF_STATUS ? '0 : status) | events;

	always_comb begin
		case (regAddr)
			`LSO_OFF_CTRL: readMux = {24'h00_0000, ctrl};
			`LSO_OFF_TAG: readMux = {24'h00_0000, spaceTagReg};
			`LSO_OFF_STATUS: readMux = {29'h0000_0000, status};
			`LSO_OFF_MASK: readMux = {24'h00_0000, maskReg};
			`LSO_OFF_QSTATE: readMux = {24'h00_0000, state, qCount};
			default: readMux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ctrl <= `LSO_RST_CTRL;
			spaceTagReg <= `LSO_RST_TAG;
			maskReg <= `LSO_RST_MASK;
			status <= '0;
			regRdata <= 32'h0000_0000;
			irq <= 1'b0;
		end else begin
			if (regWrite && regAddr == `LSO_OFF_CTRL) begin
				ctrl <= regWdata[7:0];
			end
			if (regWrite && regAddr == `LSO_OFF_TAG) begin
				spaceTagReg <= regWdata[7:0];
			end
			if (regWrite && regAddr == `LSO_OFF_MASK) begin
				maskReg <= regWdata[7:0];
			end
			status <= next_status;
			regRdata <= regRead ? readMux : 32'h0000_0000;
			irq <= |(next_status & maskReg[`LSO_EV_WIDTH-1:0]);
		end
	end
endmodule : lso_unit

// ### verification/lso_unit_sva.sv
// Concurrent checks on the ordering unit's ports.
// Assumes binding to lso_unit; all ports synchronous to clk.
module lso_unit_sva (
	input wire logic clk,
	input wire logic rstn,
	input wire logic regRead,
	input wire logic [31:0] regRdata,
	input wire logic reqValid,
	input wire logic reqReady,
	input wire logic [1:0] reqKind,
	input wire logic reqUseInstTag,
	input wire logic [7:0] reqInstTag,
	input wire logic reqCacheable,
	input wire logic reqSideEffect,
	input wire logic rspValid,
	input wire logic rspTrap,
	input wire logic busValid,
	input wire logic busReady,
	input wire logic busWrite,
	input wire logic busPrefetch,
	input wire logic [7:0] busTag,
	input wire logic [63:0] busAddr,
	input wire logic busReal
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	sequence s_take;
		reqValid && reqReady;
	endsequence
	sequence s_nf_load;
		s_take ##0 reqKind == 2'h0 && reqUseInstTag && (reqInstTag & 8'hF6) == 8'h82 && reqSideEffect;
	endsequence
	sequence s_nc_prefetch;
		s_take ##0 reqKind == 2'h2 && !reqCacheable;
	endsequence
	a_nf_trap: assert property (s_nf_load |=> rspValid && rspTrap) else $error("nonfaulting load not trapped");
	a_prefetch_nop: assert property (s_nc_prefetch |=> rspValid && !rspTrap) else $error("prefetch not a no-op");
	a_trap_flag: assert property (rspTrap |-> rspValid) else $error("trap without response");
	a_ready_drop: assert property (s_take ##0 (reqKind == 2'h0 && !reqSideEffect || reqKind == 2'h2 && reqCacheable)
		|=> !reqReady) else $error("ready held after load");
	a_bus_hold: assert property (busValid && !busReady |=> busValid && $stable(busAddr) && $stable(busWrite)
		&& $stable(busTag)) else $error("bus request changed");
	a_one_read: assert property (busValid && busReady && !busWrite && !busPrefetch |=> !busValid)
		else $error("second bus request while read open");
	a_real_tag: assert property (busValid |-> busReal == (busTag == 8'h14)) else $error("real flag wrong");
	a_store_align: assert property (busValid && busWrite |-> busAddr[3:0] == 4'h0) else $error("store unaligned");
	a_rd_idle: assert property (!regRead |=> regRdata == 32'h0000_0000) else $error("read data outside slot");
endmodule : lso_unit_sva
bind lso_unit lso_unit_sva lso_unit_sva_inst (.clk(clk), .rstn(rstn), .regRead(regRead), .regRdata(regRdata),
	.reqValid(reqValid), .reqReady(reqReady), .reqKind(reqKind), .reqUseInstTag(reqUseInstTag),
	.reqInstTag(reqInstTag), .reqCacheable(reqCacheable), .reqSideEffect(reqSideEffect), .rspValid(rspValid),
	.rspTrap(rspTrap), .busValid(busValid), .busReady(busReady), .busWrite(busWrite), .busPrefetch(busPrefetch),
	.busTag(busTag), .busAddr(busAddr), .busReal(busReal));

// ### verification/bus_memory_model.sv
// Behavioural bus and memory behind the unit: 16 regions of 16 bytes.
// Assumes the unit holds each request until busReady is high at an edge.
module bus_memory_model (
	input wire logic clk,
	input wire logic rstn,
	input wire logic stall,
	input wire logic busValid,
	output logic busReady,
	input wire logic busWrite,
	input wire logic busPrefetch,
	input wire logic [63:0] busAddr,
	input wire logic [127:0] busData,
	input wire logic [15:0] busMask,
	output logic busRspValid,
	output logic [127:0] busRspData,
	output logic [7:0] wrCount
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [127:0] mem [0:15];
	wire accept = busValid && busReady;
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			busReady <= 1'b0;
			busRspValid <= 1'b0;
			busRspData <= 128'h0;
			wrCount <= 8'h00;
			for (int i = 0; i < 16; i++) mem[i] <= 128'h0;
		end else begin
			// One at a time, taken in arrival order
			busReady <= busValid && !busReady && !stall;
			busRspValid <= accept && !busWrite && !busPrefetch;
			// Idle data toggles so a stale value never looks valid
			busRspData <= (accept && !busWrite) ? mem[busAddr[7:4]] : ~busRspData;
			if (accept && busWrite) begin
				wrCount <= wrCount + 8'h01;
				for (int i = 0; i < 16; i++) if (busMask[i]) mem[busAddr[7:4]][8*i+:8] <= busData[8*i+:8];
			end
		end
	end
endmodule : bus_memory_model

// ### verification/load_store_memory_ordering_test.sv
// Self-checking bench of the ordering unit against the behavioural bus memory.
// Assumes the register map of lso_map.svh and the unit's request contract.
`include "lso_map.svh"
module load_store_memory_ordering_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, rstn = 0, regWrite = 0, regRead = 0, reqValid = 0, reqUseInstTag = 0;
	logic reqCacheable = 0, reqSideEffect = 0, reqRetired = 1, stall = 0;
	logic [7:0] regAddr = 8'h00, reqInstTag = 8'h00, reqBytes = 8'hFF, wrCount, w0;
	logic [31:0] regWdata = 32'h0, regRdata;
	logic [1:0] reqKind = 2'h0;
	logic [63:0] reqAddr = 64'h0, reqData = 64'h0, rspData, d;
	logic reqReady, rspValid, rspTrap, busValid, busReady, busWrite, busPrefetch, t;
	logic busCacheable, busSideEffect, busReal, busRspValid, irq;
	logic [7:0] busTag;
	logic [63:0] busAddr;
	logic [127:0] busData, busRspData;
	logic [15:0] busMask;
	int mismatches = 0, cmp_count = 0;
	localparam logic [63:0] DA = 64'h1122_3344_5566_7788, DB = 64'h0BAD_F00D_1357_9BDF;
	always #50 clk = ~clk;
	lso_unit lso_unit_inst (.clk(clk), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
		.regRead(regRead), .regRdata(regRdata), .reqValid(reqValid), .reqReady(reqReady), .reqKind(reqKind),
		.reqUseInstTag(reqUseInstTag), .reqInstTag(reqInstTag), .reqAddr(reqAddr), .reqData(reqData),
		.reqBytes(reqBytes), .reqCacheable(reqCacheable), .reqSideEffect(reqSideEffect), .reqRetired(reqRetired),
		.rspValid(rspValid), .rspTrap(rspTrap), .rspData(rspData), .busValid(busValid), .busReady(busReady),
		.busWrite(busWrite), .busPrefetch(busPrefetch), .busTag(busTag), .busAddr(busAddr), .busData(busData),
		.busMask(busMask), .busCacheable(busCacheable), .busSideEffect(busSideEffect), .busReal(busReal),
		.busRspValid(busRspValid), .busRspData(busRspData), .irq(irq));
	bus_memory_model bus_memory_model_inst (.clk(clk), .rstn(rstn), .stall(stall), .busValid(busValid),
		.busReady(busReady), .busWrite(busWrite), .busPrefetch(busPrefetch), .busAddr(busAddr), .busData(busData),
		.busMask(busMask), .busRspValid(busRspValid), .busRspData(busRspData), .wrCount(wrCount));
	task results;
		if (mismatches == 0 && cmp_count > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : results
	task chk(input logic [63:0] got, input logic [63:0] exp);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		regAddr <= a;
		regWdata <= v;
		regWrite <= 1'b1;
		@(posedge clk);
		regWrite <= 1'b0;
	endtask : wr
	task rdchk(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clk);
		regRead <= 1'b0;
		@(negedge clk);
		chk(regRdata, exp);
	endtask : rdchk
	// Holds the request until ready is seen, then waits for the answer unless it is a store
	task req(input logic [1:0] k, input logic [7:0] tag, input logic [63:0] a, input logic [63:0] sd,
		input logic se, input logic c, output logic [63:0] rd, output logic tr);
		int n;
		n = 0;
		@(posedge clk);
		reqValid <= 1'b1;
		reqKind <= k;
		reqUseInstTag <= (tag != 8'h00);
		reqInstTag <= tag;
		reqAddr <= a;
		reqData <= sd;
		reqSideEffect <= se;
		reqCacheable <= c;
		do begin @(negedge clk); n++; end while (!reqReady && n < 200);
		@(posedge clk);
		reqValid <= 1'b0;
		if (k != 2'h1) begin
			do begin @(negedge clk); n++; end while (!rspValid && n < 200);
			rd = rspData;
			tr = rspTrap;
		end
		if (n >= 200) begin
			mismatches++;
			results();
		end
	endtask : req
	initial begin
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		repeat (2) @(posedge clk);
		rdchk(`LSO_OFF_CTRL, 32'h0000_0001);
		rdchk(`LSO_OFF_TAG, 32'h0000_0080);
		rdchk(`LSO_OFF_MASK, 32'h0000_0000);
		rdchk(`LSO_OFF_STATUS, 32'h0000_0000);
		rdchk(`LSO_OFF_QSTATE, 32'h0000_0008);
		wr(8'h20, 32'hFFFF_FFFF);
		rdchk(8'h20, 32'h0000_0000);
		// Plain noncacheable store then loads, both attributes and byte orders
		req(2'h1, 8'h00, 64'h208, DA, 1'b0, 1'b0, d, t);
		req(2'h0, 8'h00, 64'h208, 64'h0, 1'b0, 1'b0, d, t);
		chk(d, DA);
		req(2'h0, 8'h00, 64'h208, 64'h0, 1'b0, 1'b1, d, t);
		chk(d, DA);
		req(2'h0, 8'h88, 64'h208, 64'h0, 1'b0, 1'b0, d, t);
		chk(d, 64'h8877_6655_4433_2211);
		// Side-effect stores in one region with the bus stalled: no merging
		w0 = wrCount;
		stall <= 1'b1;
		fork
			begin
				req(2'h1, 8'h00, 64'h300, DA, 1'b1, 1'b0, d, t);
				req(2'h1, 8'h00, 64'h308, DB, 1'b1, 1'b0, d, t);
			end
			begin
				repeat (6) @(posedge clk);
				stall <= 1'b0;
			end
		join
		repeat (20) @(negedge clk);
		chk(wrCount, w0 + 8'h02);
		req(2'h0, 8'h00, 64'h308, 64'h0, 1'b1, 1'b0, d, t);
		chk(d, DB);
		// Side-effect load waits for earlier instructions to retire
		reqRetired <= 1'b0;
		fork
			req(2'h0, 8'h00, 64'h300, 64'h0, 1'b1, 1'b0, d, t);
			begin
				repeat (10) begin @(negedge clk); chk(busValid, 1'b0); end
				@(posedge clk);
				reqRetired <= 1'b1;
				repeat (2) @(negedge clk);
				chk({busValid, busSideEffect, busCacheable}, 3'b110);
			end
		join
		chk(d, DA);
		// Nonfaulting codes trap on side-effect pages; status and interrupt follow
		wr(`LSO_OFF_MASK, 32'h0000_0007);
		rdchk(`LSO_OFF_STATUS, 32'h0000_0004);
		foreach (w0[i]) if (i < 4) begin
			req(2'h0, 8'h82 | {4'h0, i[1], 2'h0, i[0]}, 64'h400, 64'h0, 1'b1, 1'b0, d, t);
			chk(t, 1'b1);
		end
		repeat (2) @(negedge clk);
		chk(irq, 1'b1);
		rdchk(`LSO_OFF_STATUS, 32'h0000_0001);
		repeat (2) @(negedge clk);
		chk(irq, 1'b0);
		req(2'h2, 8'h00, 64'h500, 64'h0, 1'b0, 1'b0, d, t);
		chk(t, 1'b0);
		req(2'h2, 8'h00, 64'h500, 64'h0, 1'b0, 1'b1, d, t);
		chk(t, 1'b0);
		rdchk(`LSO_OFF_STATUS, 32'h0000_0002);
		wr(`LSO_OFF_MASK, 32'h0000_0000);
		req(2'h0, 8'h82, 64'h400, 64'h0, 1'b1, 1'b0, d, t);
		repeat (2) @(negedge clk);
		chk(irq, 1'b0);
		rdchk(`LSO_OFF_STATUS, 32'h0000_0001);
		results();
	end
endmodule : load_store_memory_ordering_test
